/* File: pkg/adc_out_pkg.sv */
// constants and carrier types for the converter output path
package adc_out_pkg;

    // -------------------------------------------------------------
    // widths and pipeline figures
    // -------------------------------------------------------------
    localparam int SMP_W      = 14;   // accurate (unclipped) sample, signed
    localparam int CODE_W     = 12;   // output code width
    localparam int PIPE_DEPTH = 36;   // enough stages for the longest tap
    localparam int LAT_PRI    = 34;   // primary bus latency, sampling cycles
    localparam int LAT_DLY    = 35;   // delayed bus latency, sampling cycles
    localparam int CNT_W      = 6;

    // flush time after calibration, in sampling clock cycles
    localparam logic [CNT_W-1:0] CAL_FLUSH_CYC = 6'h3c;

    // -------------------------------------------------------------
    // code limits for clipping
    // -------------------------------------------------------------
    localparam logic signed [SMP_W-1:0] ACC_MAX  = 14'sh0fff;
    localparam logic signed [SMP_W-1:0] ACC_MIN  = 14'sh0000;
    localparam logic [CODE_W-1:0]       CODE_MAX = 12'hfff;
    localparam logic [CODE_W-1:0]       CODE_MIN = 12'h000;

    // -------------------------------------------------------------
    // register map and full-scale values
    // -------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int REG_W  = 16;
    localparam logic [ADDR_W-1:0] ADDR_I_FULL_SCALE = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_Q_FULL_SCALE = 4'hb;
    localparam logic [REG_W-1:0]  FULL_SCALE_RESET  = 16'h4000;
    localparam logic [REG_W-1:0]  FULL_SCALE_PIN_LO = 16'h2000;
    localparam logic [REG_W-1:0]  FULL_SCALE_PIN_HI = 16'h6000;
    localparam logic [REG_W-1:0]  FULL_SCALE_MASK   = 16'h7fff; // 15-bit precision

    // dual-edge input selection
    typedef enum logic [1:0] {
        SEL_I_ONLY = 2'h0,
        SEL_Q_ONLY = 2'h1,
        SEL_BOTH   = 2'h2
    } in_sel_t;

    // one output word: clipped code plus its over-range mark
    typedef struct packed {
        logic              ovr;
        logic [CODE_W-1:0] code;
    } word_t;

    // control pins, synchronised as one group
    typedef struct packed {
        logic       extended_control_mode;
        logic       des;
        logic       demux;
        logic       fs_high;
        logic [1:0] in_sel;
        logic       cal_run;
    } pins_t;

    // analog results presented as accurate digital values
    typedef struct packed {
        logic signed [SMP_W-1:0] i_acc;
        logic signed [SMP_W-1:0] q_acc;
    } samples_t;

endpackage

/* File: hdl/adc_output_latency_overrange.sv */
// sampling, latency pipelines, clipping and over-range flags of the converter
//
// Overview of operation
// [R1] convert continuously while sampling clock runs
// [R2] sample on rise, also fall in dual-edge
// [R3] primary buses show rise sample 34 earlier
// [R4] delayed buses show rise sample 35 earlier
// [R5] dual-edge Q buses show fall samples 34.5/35.5
// [R6] non-demux: delayed buses undriven, primaries only
// [R7] non-demux dual-edge: I 34, Q 34.5
// [R8] Q input in dual-edge only under extended control
// [R9] input selection: I-only default, Q-only, both
// [R10] full scale: pin for both, registers per channel
// [R11] clip to all ones or all zeros
// [R12] I flag while either I word out of range
// [R13] Q flag likewise for Q words
// [R14] outputs blank 60 cycles after calibration ends
// [R15] fall samples realigned to rising output timing
`timescale 1ns/1ps

module adc_output_latency_overrange (
    input  wire logic                                clk_sys_i,
    input  wire logic                                rst_i,
    input  wire logic                                sample_clk_i,
    input  wire adc_out_pkg::samples_t               samples_i,
    input  wire logic                                extended_control_mode_i,
    input  wire logic                                dual_edge_i,
    input  wire logic                                demux_i,
    input  wire logic                                full_scale_select_i,
    input  wire logic [1:0]                          input_select_i,
    input  wire logic                                calibration_running_i,
    input  wire logic                                reg_wr_i,
    input  wire logic [adc_out_pkg::ADDR_W-1:0]      reg_addr_i,
    input  wire logic [adc_out_pkg::REG_W-1:0]       reg_wdata_i,
    output logic      [adc_out_pkg::REG_W-1:0]       reg_rdata_o,
    output logic      [adc_out_pkg::REG_W-1:0]       i_full_scale_o,
    output logic      [adc_out_pkg::REG_W-1:0]       q_full_scale_o,
    output logic      [adc_out_pkg::CODE_W-1:0]      i_primary_bus_o,
    output logic      [adc_out_pkg::CODE_W-1:0]      i_delayed_bus_o,
    output logic      [adc_out_pkg::CODE_W-1:0]      q_primary_bus_o,
    output logic      [adc_out_pkg::CODE_W-1:0]      q_delayed_bus_o,
    output logic                                     delayed_bus_oe_n_o,
    output logic                                     i_overrange_flag_o,
    output logic                                     q_overrange_flag_o,
    output logic                                     data_valid_o
);

    // -------------------------------------------------------------
    // clipping
    // -------------------------------------------------------------
    function automatic adc_out_pkg::word_t clip(input logic signed [adc_out_pkg::SMP_W-1:0] acc);
        adc_out_pkg::word_t w;
        w.ovr  = 1'b0;
        w.code = acc[adc_out_pkg::CODE_W-1:0];
        if (acc > adc_out_pkg::ACC_MAX) begin
            w.ovr  = 1'b1;
            w.code = adc_out_pkg::CODE_MAX;
        end else if (acc < adc_out_pkg::ACC_MIN) begin
            w.ovr  = 1'b1;
            w.code = adc_out_pkg::CODE_MIN;
        end
        return w;
    endfunction

    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    adc_out_pkg::pins_t    pins_meta_ff, pins_ff;
    adc_out_pkg::samples_t smp_meta_ff, smp_ff;
    logic                  sclk_meta_ff, sclk_ff, sclk_prev_ff;
    adc_out_pkg::pins_t    pins_raw;
    logic                  rise_ev, fall_ev;

    assign pins_raw = '{extended_control_mode: extended_control_mode_i, des: dual_edge_i, demux: demux_i,
                        fs_high: full_scale_select_i, in_sel: input_select_i,
                        cal_run: calibration_running_i};

    // two stages on every pin, edge detect on the second only
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pins_meta_ff <= '0;
            pins_ff      <= '0;
            smp_meta_ff  <= '0;
            smp_ff       <= '0;
            sclk_meta_ff <= 1'b0;
            sclk_ff      <= 1'b0;
            sclk_prev_ff <= 1'b0;
        end else begin
            pins_meta_ff <= pins_raw;
            pins_ff      <= pins_meta_ff;
            smp_meta_ff  <= samples_i;
            smp_ff       <= smp_meta_ff;
            sclk_meta_ff <= sample_clk_i;
            sclk_ff      <= sclk_meta_ff;
            sclk_prev_ff <= sclk_ff;
        end
    end

    // [R1] free-running edge finder, no start command
    assign rise_ev = sclk_ff & ~sclk_prev_ff;
    assign fall_ev = ~sclk_ff & sclk_prev_ff & pins_ff.des;

    // -------------------------------------------------------------
    // input selection and sample words
    // -------------------------------------------------------------
    adc_out_pkg::in_sel_t sel_eff;
    adc_out_pkg::word_t   i_word, q_word, sel_word;

    // [R8] Q input only reachable under extended control
    always_comb begin
        sel_eff = adc_out_pkg::SEL_I_ONLY;
        if (pins_ff.extended_control_mode && pins_ff.in_sel == adc_out_pkg::SEL_Q_ONLY) begin
            sel_eff = adc_out_pkg::SEL_Q_ONLY;
        end
    end

    // [R9] both-inputs mode drives identically, so the I side serves
    // [R11] clip each result to the 12-bit code range
    assign i_word   = clip(smp_ff.i_acc);
    assign q_word   = clip(smp_ff.q_acc);
    assign sel_word = (sel_eff == adc_out_pkg::SEL_Q_ONLY) ? q_word : i_word;

    // -------------------------------------------------------------
    // latency pipelines
    // -------------------------------------------------------------
    adc_out_pkg::word_t rise_i_ff [adc_out_pkg::PIPE_DEPTH];
    adc_out_pkg::word_t rise_q_ff [adc_out_pkg::PIPE_DEPTH];
    adc_out_pkg::word_t fall_ff   [adc_out_pkg::PIPE_DEPTH];
    adc_out_pkg::word_t nxt_rise_i[adc_out_pkg::PIPE_DEPTH];
    adc_out_pkg::word_t nxt_rise_q[adc_out_pkg::PIPE_DEPTH];
    adc_out_pkg::word_t nxt_fall  [adc_out_pkg::PIPE_DEPTH];
    logic               rise_d_ff, nxt_rise_d;

    // [R2] shift rise stages on rise, fall stage on fall
    always_comb begin
        nxt_rise_i = rise_i_ff;
        nxt_rise_q = rise_q_ff;
        nxt_fall   = fall_ff;
        nxt_rise_d = rise_ev;
        if (rise_ev) begin
            for (int k = adc_out_pkg::PIPE_DEPTH - 1; k > 0; k--) begin
                nxt_rise_i[k] = rise_i_ff[k-1];
                nxt_rise_q[k] = rise_q_ff[k-1];
            end
            nxt_rise_i[0] = pins_ff.des ? sel_word : i_word;
            nxt_rise_q[0] = q_word;
        end
        if (fall_ev) begin
            for (int k = adc_out_pkg::PIPE_DEPTH - 1; k > 0; k--) begin
                nxt_fall[k] = fall_ff[k-1];
            end
            nxt_fall[0] = sel_word;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            for (int k = 0; k < adc_out_pkg::PIPE_DEPTH; k++) begin
                rise_i_ff[k] <= '0;
                rise_q_ff[k] <= '0;
                fall_ff[k]   <= '0;
            end
            rise_d_ff <= 1'b0;
        end else begin
            rise_i_ff <= nxt_rise_i;
            rise_q_ff <= nxt_rise_q;
            fall_ff   <= nxt_fall;
            rise_d_ff <= nxt_rise_d;
        end
    end

    // -------------------------------------------------------------
    // calibration blanking
    // -------------------------------------------------------------
    logic [adc_out_pkg::CNT_W-1:0] blank_cnt_ff, nxt_blank_cnt;

    // [R14] reload while calibrating, count down on rising edges
    always_comb begin
        nxt_blank_cnt = blank_cnt_ff;
        if (pins_ff.cal_run) begin
            nxt_blank_cnt = adc_out_pkg::CAL_FLUSH_CYC;
        end else if (rise_ev && blank_cnt_ff != '0) begin
            nxt_blank_cnt = blank_cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            blank_cnt_ff <= adc_out_pkg::CAL_FLUSH_CYC;
        end else begin
            blank_cnt_ff <= nxt_blank_cnt;
        end
    end

    // -------------------------------------------------------------
    // output stage, loaded on rising sampling edges, cleared at once by calibration, delayed buses also by demux off
    // -------------------------------------------------------------
    adc_out_pkg::word_t ip_ff, id_ff, qp_ff, qd_ff, nxt_ip, nxt_id, nxt_qp, nxt_qd;
    logic               oe_n_ff, nxt_oe_n, valid_ff, nxt_valid;
    logic               i_flag_ff, q_flag_ff, nxt_i_flag, nxt_q_flag;

    always_comb begin
        nxt_ip    = ip_ff;
        nxt_id    = id_ff;
        nxt_qp    = qp_ff;
        nxt_qd    = qd_ff;
        nxt_valid = valid_ff;
        // [R6] delayed buses released when not demultiplexed
        nxt_oe_n  = ~pins_ff.demux;
        if (pins_ff.cal_run) begin
            nxt_ip    = '0;
            nxt_id    = '0;
            nxt_qp    = '0;
            nxt_qd    = '0;
            nxt_valid = 1'b0;
        end else if (rise_d_ff) begin
            // [R3] primary taps 34 rises back
            nxt_ip = rise_i_ff[adc_out_pkg::LAT_PRI];
            nxt_qp = rise_q_ff[adc_out_pkg::LAT_PRI];
            // [R4] delayed taps one rise further
            nxt_id = rise_i_ff[adc_out_pkg::LAT_DLY];
            nxt_qd = rise_q_ff[adc_out_pkg::LAT_DLY];
            if (pins_ff.des) begin
                // [R5] [R7] [R15] fall taps read at the rising edge
                nxt_qp = fall_ff[adc_out_pkg::LAT_PRI];
                nxt_qd = fall_ff[adc_out_pkg::LAT_DLY];
            end
            nxt_valid = (blank_cnt_ff == '0);
            if (blank_cnt_ff != '0) begin
                nxt_ip = '0;
                nxt_id = '0;
                nxt_qp = '0;
                nxt_qd = '0;
            end
        end
        // [R6] released delayed buses cleared at once, not at next rise
        if (!pins_ff.demux) begin
            nxt_id = '0;
            nxt_qd = '0;
        end
        // [R12] I flag from either I word
        nxt_i_flag = nxt_ip.ovr | nxt_id.ovr;
        // [R13] Q flag from either Q word
        nxt_q_flag = nxt_qp.ovr | nxt_qd.ovr;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ip_ff    <= '0;
            id_ff    <= '0;
            qp_ff    <= '0;
            qd_ff    <= '0;
            oe_n_ff  <= 1'b1;
            valid_ff <= 1'b0;
            i_flag_ff <= 1'b0;
            q_flag_ff <= 1'b0;
        end else begin
            ip_ff    <= nxt_ip;
            id_ff    <= nxt_id;
            qp_ff    <= nxt_qp;
            qd_ff    <= nxt_qd;
            oe_n_ff  <= nxt_oe_n;
            valid_ff <= nxt_valid;
            i_flag_ff <= nxt_i_flag;
            q_flag_ff <= nxt_q_flag;
        end
    end

    assign i_primary_bus_o    = ip_ff.code;
    assign i_delayed_bus_o    = id_ff.code;
    assign q_primary_bus_o    = qp_ff.code;
    assign q_delayed_bus_o    = qd_ff.code;
    assign delayed_bus_oe_n_o = oe_n_ff;
    assign data_valid_o       = valid_ff;
    assign i_overrange_flag_o = i_flag_ff;
    assign q_overrange_flag_o = q_flag_ff;

    // -------------------------------------------------------------
    // full-scale registers and selection
    // -------------------------------------------------------------
    logic [adc_out_pkg::REG_W-1:0] i_fs_ff, q_fs_ff, rdata_ff, ifs_out_ff, qfs_out_ff;
    logic [adc_out_pkg::REG_W-1:0] nxt_i_fs, nxt_q_fs, nxt_rdata, nxt_ifs_out, nxt_qfs_out;

    // [R10] per-channel registers under extended control, else one pin
    always_comb begin
        nxt_i_fs  = i_fs_ff;
        nxt_q_fs  = q_fs_ff;
        nxt_rdata = '0;
        if (reg_wr_i && reg_addr_i == adc_out_pkg::ADDR_I_FULL_SCALE) begin
            nxt_i_fs = reg_wdata_i & adc_out_pkg::FULL_SCALE_MASK;
        end
        if (reg_wr_i && reg_addr_i == adc_out_pkg::ADDR_Q_FULL_SCALE) begin
            nxt_q_fs = reg_wdata_i & adc_out_pkg::FULL_SCALE_MASK;
        end
        if (reg_addr_i == adc_out_pkg::ADDR_I_FULL_SCALE) begin
            nxt_rdata = i_fs_ff;
        end else if (reg_addr_i == adc_out_pkg::ADDR_Q_FULL_SCALE) begin
            nxt_rdata = q_fs_ff;
        end
        if (pins_ff.extended_control_mode) begin
            nxt_ifs_out = i_fs_ff;
            nxt_qfs_out = q_fs_ff;
        end else begin
            nxt_ifs_out = pins_ff.fs_high ? adc_out_pkg::FULL_SCALE_PIN_HI
                                          : adc_out_pkg::FULL_SCALE_PIN_LO;
            nxt_qfs_out = nxt_ifs_out;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            i_fs_ff    <= adc_out_pkg::FULL_SCALE_RESET;
            q_fs_ff    <= adc_out_pkg::FULL_SCALE_RESET;
            rdata_ff   <= '0;
            ifs_out_ff <= adc_out_pkg::FULL_SCALE_PIN_LO;
            qfs_out_ff <= adc_out_pkg::FULL_SCALE_PIN_LO;
        end else begin
            i_fs_ff    <= nxt_i_fs;
            q_fs_ff    <= nxt_q_fs;
            rdata_ff   <= nxt_rdata;
            ifs_out_ff <= nxt_ifs_out;
            qfs_out_ff <= nxt_qfs_out;
        end
    end

    assign reg_rdata_o    = rdata_ff;
    assign i_full_scale_o = ifs_out_ff;
    assign q_full_scale_o = qfs_out_ff;

endmodule

/* File: verif/adc_out_monitor.sv */
// assertion checker for the converter output block
`timescale 1ns/1ps

module adc_out_monitor (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        sample_clk_i,
    input wire logic        extended_control_mode_i,
    input wire logic        demux_i,
    input wire logic        full_scale_select_i,
    input wire logic        calibration_running_i,
    input wire logic        reg_wr_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [15:0] i_full_scale_o,
    input wire logic [15:0] q_full_scale_o,
    input wire logic [11:0] i_primary_bus_o,
    input wire logic [11:0] i_delayed_bus_o,
    input wire logic [11:0] q_primary_bus_o,
    input wire logic [11:0] q_delayed_bus_o,
    input wire logic        delayed_bus_oe_n_o,
    input wire logic        i_overrange_flag_o,
    input wire logic        q_overrange_flag_o,
    input wire logic        data_valid_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // ---------------------------------------------------------------
    // output path
    // ---------------------------------------------------------------
    a_bus_on_rise: assert property (
        $changed(i_primary_bus_o) |-> $past(sample_clk_i, 3) || $past(calibration_running_i, 2)
        || $past(calibration_running_i, 3) || $past(calibration_running_i, 4))
        else $error("primary bus moved away from a sampling rise");
    a_valid_on_rise: assert property (
        $rose(data_valid_o) |-> $past(sample_clk_i, 3))
        else $error("valid rose away from a sampling rise");
    a_cal_blanks: assert property (
        calibration_running_i [*5] |-> !data_valid_o && i_primary_bus_o == 12'h000
        && q_primary_bus_o == 12'h000 && !i_overrange_flag_o && !q_overrange_flag_o)
        else $error("outputs not blank during calibration");
    a_delayed_idle: assert property (
        delayed_bus_oe_n_o |-> i_delayed_bus_o == 12'h000 && q_delayed_bus_o == 12'h000)
        else $error("released delayed bus carries data");
    a_nondemux_off: assert property (
        (!demux_i) [*5] |-> delayed_bus_oe_n_o)
        else $error("delayed buses driven in non-demux");
    a_i_flag_clip: assert property (
        i_overrange_flag_o |-> i_primary_bus_o inside {12'h000, 12'hfff}
        || i_delayed_bus_o inside {12'h000, 12'hfff})
        else $error("i flag without clipped word");
    a_q_flag_clip: assert property (
        q_overrange_flag_o |-> q_primary_bus_o inside {12'h000, 12'hfff}
        || q_delayed_bus_o inside {12'h000, 12'hfff})
        else $error("q flag without clipped word");

    // ---------------------------------------------------------------
    // full scale registers and pin
    // ---------------------------------------------------------------
    a_write_read: assert property (
        (reg_wr_i && reg_addr_i == 4'h3) ##1 (!reg_wr_i && reg_addr_i == 4'h3)
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'h7fff))
        else $error("i full scale read back wrong");
    a_unmapped_zero: assert property (
        !(reg_addr_i inside {4'h3, 4'hb}) |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_pin_scale: assert property (
        (!extended_control_mode_i && $stable(full_scale_select_i)) [*5]
        |-> i_full_scale_o == q_full_scale_o && i_full_scale_o == (full_scale_select_i ?
        adc_out_pkg::FULL_SCALE_PIN_HI : adc_out_pkg::FULL_SCALE_PIN_LO))
        else $error("pin full scale wrong");

    // main scenarios reached
    c_cal: cover property (calibration_running_i [*5]);
    c_flag: cover property (i_overrange_flag_o && !delayed_bus_oe_n_o);
    c_valid: cover property ($rose(data_valid_o));
endmodule

bind adc_output_latency_overrange adc_out_monitor u_mon (
    .clk_sys_i, .rst_i, .sample_clk_i, .extended_control_mode_i, .demux_i,
    .full_scale_select_i, .calibration_running_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .i_full_scale_o, .q_full_scale_o, .i_primary_bus_o, .i_delayed_bus_o,
    .q_primary_bus_o, .q_delayed_bus_o, .delayed_bus_oe_n_o, .i_overrange_flag_o,
    .q_overrange_flag_o, .data_valid_o
);

/* File: verif/sample_source.sv */
// behavioural sampling clock and analog sample source
`timescale 1ns/1ps

module sample_source (
    output logic                  sample_clk_o,
    output adc_out_pkg::samples_t samples_o,
    output int                    rise_cnt_o
);
    logic signed [13:0] hist_i [0:4095];
    logic signed [13:0] hist_q [0:4095];
    int                 n;

    // free-running clock, samples move midway between edges, odd edges rise
    initial begin
        sample_clk_o = 1'b0;
        rise_cnt_o = 0;
        n = 0;
        forever begin
            n = n + 1;
            hist_i[n] = (n % 13 == 7) ? 14'sh1400 : 14'((n * 37 + 5) % 4096);
            hist_q[n] = (n % 11 == 4) ? -14'sh0009 : 14'((n * 91 + 11) % 4096);
            samples_o = {hist_i[n], hist_q[n]};
            #40;
            sample_clk_o = ~sample_clk_o;
            if (sample_clk_o) rise_cnt_o = rise_cnt_o + 1;
            #40;
        end
    end
endmodule

/* File: verif/adc_output_latency_overrange_bench.sv */
// self-checking bench for the converter output block
`timescale 1ns/1ps

module adc_output_latency_overrange_bench;
    logic        clk_sys_i, rst_i, sample_clk_i, extended_control_mode_i, dual_edge_i;
    logic        demux_i, full_scale_select_i, calibration_running_i, reg_wr_i;
    logic [1:0]  input_select_i;
    logic [3:0]  reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, i_full_scale_o, q_full_scale_o;
    logic [11:0] i_primary_bus_o, i_delayed_bus_o, q_primary_bus_o, q_delayed_bus_o;
    logic        delayed_bus_oe_n_o, i_overrange_flag_o, q_overrange_flag_o, data_valid_o;
    adc_out_pkg::samples_t samples_i;
    int          rise_cnt, errors, check_count;

    // ---------------------------------------------------------------
    // design and sample source
    // ---------------------------------------------------------------
    adc_output_latency_overrange u_dut (
        .clk_sys_i, .rst_i, .sample_clk_i, .samples_i, .extended_control_mode_i,
        .dual_edge_i, .demux_i, .full_scale_select_i, .input_select_i,
        .calibration_running_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .i_full_scale_o, .q_full_scale_o, .i_primary_bus_o, .i_delayed_bus_o,
        .q_primary_bus_o, .q_delayed_bus_o, .delayed_bus_oe_n_o, .i_overrange_flag_o,
        .q_overrange_flag_o, .data_valid_o
    );
    sample_source u_src (.sample_clk_o(sample_clk_i), .samples_o(samples_i), .rise_cnt_o(rise_cnt));

    // 50 MHz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic tick(input int k = 1);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic final_report();
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    // bounded wait for each sampling rise, then let the outputs settle
    task automatic wait_rise(input int k = 1);
        int start;
        repeat (k) begin
            start = rise_cnt;
            for (int t = 0; t < 20 && rise_cnt == start; t++) tick();
            if (rise_cnt == start) begin
                errors++;
                final_report();
            end
            tick(6);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        tick();
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [15:0] e);
        reg_wr_i = 1'b0;
        reg_addr_i = a;
        tick();
        chk(reg_rdata_o === e, "register read");
    endtask

    // clipped word, over-range mark on top
    function automatic logic [12:0] word_at(input logic from_q, input int n);
        logic signed [13:0] v;
        v = from_q ? u_src.hist_q[n] : u_src.hist_i[n];
        if (v > 14'sh0fff) return 13'h1fff;
        if (v < 14'sh0000) return 13'h1000;
        return {1'b0, v[11:0]};
    endfunction

    // set a mode, refill the pipeline, compare three updates
    task automatic run_paths(input logic d, m, e, input logic [1:0] s);
        logic [12:0] ip, id, qp, qd;
        logic        sq;
        {dual_edge_i, demux_i, extended_control_mode_i, input_select_i} = {d, m, e, s};
        sq = d & e & (s == 2'h1);
        wait_rise(40);
        repeat (3) begin
            ip = word_at(sq, 2 * rise_cnt - 69);
            id = word_at(sq, 2 * rise_cnt - 71);
            qp = d ? word_at(sq, 2 * rise_cnt - 70) : word_at(1'b1, 2 * rise_cnt - 69);
            qd = d ? word_at(sq, 2 * rise_cnt - 72) : word_at(1'b1, 2 * rise_cnt - 71);
            chk(i_primary_bus_o === ip[11:0] && q_primary_bus_o === qp[11:0], "primary");
            chk(data_valid_o === 1'b1, "valid");
            if (m) begin
                chk(i_delayed_bus_o === id[11:0] && q_delayed_bus_o === qd[11:0], "delayed");
                chk(i_overrange_flag_o === (ip[12] | id[12]), "i flag");
                chk(q_overrange_flag_o === (qp[12] | qd[12]), "q flag");
            end else begin
                chk(delayed_bus_oe_n_o === 1'b1 && i_delayed_bus_o === 12'h000, "release");
            end
            wait_rise();
        end
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        extended_control_mode_i = 1'b1;
        reg_read(4'h3, adc_out_pkg::FULL_SCALE_RESET);
        reg_write(4'hb, 16'h1234);
        reg_write(4'h5, 16'h5555);
        reg_write(4'h3, 16'hffff);
        reg_read(4'h3, 16'h7fff);
        reg_read(4'hb, 16'h1234);
        reg_read(4'h5, 16'h0000);
        chk(i_full_scale_o === 16'h7fff && q_full_scale_o === 16'h1234, "reg scale");
        extended_control_mode_i = 1'b0;
        full_scale_select_i = 1'b1;
        tick(5);
        chk(q_full_scale_o === adc_out_pkg::FULL_SCALE_PIN_HI, "pin scale");
        full_scale_select_i = 1'b0;
    endtask

    task automatic t_latency();
        wait_rise(25);
        run_paths(1'b0, 1'b1, 1'b0, 2'h0);
        run_paths(1'b1, 1'b1, 1'b0, 2'h0);
    endtask

    task automatic t_input_select();
        run_paths(1'b1, 1'b1, 1'b1, 2'h1);
        run_paths(1'b1, 1'b1, 1'b0, 2'h1);
        run_paths(1'b1, 1'b1, 1'b1, 2'h2);
    endtask

    task automatic t_nondemux();
        run_paths(1'b0, 1'b0, 1'b0, 2'h0);
        run_paths(1'b1, 1'b0, 1'b0, 2'h0);
    endtask

    task automatic t_calibration();
        calibration_running_i = 1'b1;
        wait_rise(3);
        chk(data_valid_o === 1'b0 && q_primary_bus_o === 12'h000, "cal blank");
        calibration_running_i = 1'b0;
        wait_rise(59);
        chk(data_valid_o === 1'b0 && i_primary_bus_o === 12'h000, "flush blank");
        wait_rise();
        chk(data_valid_o === 1'b1, "flush end");
    endtask

    // main sequence
    initial begin
        rst_i = 1'b1;
        {extended_control_mode_i, dual_edge_i, demux_i, full_scale_select_i} = '0;
        {calibration_running_i, reg_wr_i, input_select_i, reg_addr_i, reg_wdata_i} = '0;
        tick(8);
        chk(delayed_bus_oe_n_o === 1'b1 && data_valid_o === 1'b0, "reset state");
        rst_i = 1'b0;
        tick();
        t_regs();
        t_latency();
        t_input_select();
        t_nondemux();
        t_calibration();
        final_report();
    end
endmodule
